/* core/bfsup_pkg.sv */
package bfsup_pkg;

  // ------------------------------------------------------------
  // Clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_MHZ        = 250;
  localparam int unsigned BLANK_NS       = 1000;   // Blanking interval, ns
  localparam int unsigned SLP_CLR_MIN_US = 20;     // Reset pulse, lower bound, us
  localparam int unsigned SLP_CLR_MAX_US = 40;     // Reset pulse, upper bound, us
  // Least times round up to whole cycles
  localparam int unsigned BLANK_CYC      = (BLANK_NS * CLK_MHZ + 999) / 1000;
  localparam int unsigned SLP_CLR_MIN_CYC = SLP_CLR_MIN_US * CLK_MHZ;
  localparam int unsigned SLP_CLR_MAX_CYC = SLP_CLR_MAX_US * CLK_MHZ;
  // Filter and retry waits have no fixed figure; plain defaults
  localparam int unsigned OCP_FILT_CYC_DEF = 1000;
  localparam int unsigned RETRY_CYC_DEF    = 4000;

  // ------------------------------------------------------------
  // Register map (byte addresses)
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_OFS   = 4'h0;
  localparam logic [3:0] STATUS_OFS = 4'h4;

  // Control register fields
  localparam int unsigned CTRL_BRIDGE_OFF_BIT = 0;
  localparam int unsigned CTRL_CLEAR_BIT      = 1;
  localparam logic        CTRL_BRIDGE_OFF_RST = 1'b0;

  // Status register fields
  localparam int unsigned ST_SUPPLY_UV_BIT = 0;
  localparam int unsigned ST_PUMP_UV_BIT   = 1;
  localparam int unsigned ST_OCP_BIT       = 2;
  localparam int unsigned ST_THERMAL_BIT   = 3;
  localparam int unsigned ST_SLEEP_BIT     = 4;
  localparam int unsigned ST_LATCHED_BIT   = 5;
  localparam int unsigned ST_FAULT_BIT     = 6;
  localparam int unsigned ST_BRIDGE_OFF_BIT = 7;

  // Overcurrent supervisor states
  typedef enum logic [0:0] {
    BFSUP_OC_RUN,
    BFSUP_OC_TRIP
  } bfsup_oc_state_e;

endpackage

/* core/bfsup_blank.sv */
`timescale 1ns/1ps
module bfsup_blank
  import bfsup_pkg::*;
#(
  parameter int unsigned BLANK_CYCLES = BLANK_CYC
) (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic drive_req,
  input  wire logic kill,
  input  wire logic trip_raw,
  output logic      drive,
  output logic      trip
);

  initial begin
    if (BLANK_CYCLES < 1 || BLANK_CYCLES > 65535) begin
      $error("BLANK_CYCLES out of range");
    end
  end

  logic [15:0] cnt_reg;
  logic [15:0] cnt_next;
  logic        drive_next;
  wire logic   blanking = (cnt_reg != 16'h0000);
  wire logic   start    = !drive && drive_req;

  // ------------------------------------------------------------
  // Phase sequencing
  // ------------------------------------------------------------
  // A phase start loads the blank count; only kill can end the phase early
  always_comb begin
    cnt_next   = cnt_reg;
    drive_next = drive;
    if (kill) begin
      cnt_next   = 16'h0000;
      drive_next = 1'b0;
    end else if (start) begin
      cnt_next   = BLANK_CYCLES[15:0];                      // [RQ1]
      drive_next = 1'b1;
    end else if (drive && blanking) begin
      cnt_next   = cnt_reg - 16'h0001;                      // [RQ2]
    end else if (drive && !drive_req) begin
      drive_next = 1'b0;                                    // [RQ2]
    end
  end

  // Comparator counts only once blanking has run out
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 16'h0000;
      drive   <= 1'b0;
      trip    <= 1'b0;
    end else begin
      cnt_reg <= cnt_next;
      drive   <= drive_next;
      trip    <= drive && !blanking && !kill && trip_raw;   // [RQ1]
    end
  end

endmodule // bfsup_blank

/* core/bfsup_top.sv */
// Overview of operation
// [RQ1] Each bridge ignores its current comparator for the blanking interval after a drive start.
// [RQ2] A drive phase never ends before the blanking interval, which is the least PWM on-time; the code ends it early when bridge_off kills it.
// [RQ3] The fault line is pulled low while any fault stands and is released after power-up.
// [RQ4] Supply undervoltage turns off bridges and pump, flags a fault, and recovers by itself.
// [RQ5] Pump undervoltage turns off bridges, keeps the pump, flags a fault, and recovers by itself.
// [RQ6] A FET current limit held past the filter time turns off both bridges, keeping the pump.
// [RQ7] The enable level picks latched (high-impedance) or retry (high) overcurrent recovery.
// [RQ8] Latched overcurrent stays off until a sleep reset pulse or a power cycle; the code also releases it on the control clear bit.
// [RQ9] Retry overcurrent recovers after the retry wait once the overcurrent is gone.
// [RQ10] Overtemperature turns off bridges and pump and flags a fault; indexer and logic run on.
// [RQ11] The enable level picks latched or retry thermal recovery in the same way.
// [RQ12] Latched thermal shutdown stays off after cooling until a sleep reset pulse or power cycle; the code also clears it on the control clear bit.
// [RQ13] Retry thermal shutdown recovers as soon as the die has cooled past the hysteresis.
// [RQ14] A sleep low pulse longer than 20 us clears latched faults; under 40 us it does not sleep.
// [RQ15] With sleep high and enable low the bridge outputs are held in high impedance.
// [RQ16] Detector inputs are synchronised and the fault is the OR of all live or held faults.
//
// The address map and register access over Avalon-MM were decided locally.
`timescale 1ns/1ps
module bfsup_top
  import bfsup_pkg::*;
#(
  parameter int unsigned N_BRIDGE       = 2,
  parameter int unsigned N_FET          = 8,
  parameter int unsigned OCP_FILT_CYCLES = OCP_FILT_CYC_DEF,
  parameter int unsigned RETRY_CYCLES   = RETRY_CYC_DEF,
  parameter int unsigned SLP_MIN_CYCLES = SLP_CLR_MIN_CYC,
  parameter int unsigned SLP_MAX_CYCLES = SLP_CLR_MAX_CYC
) (
  input  wire logic                mclk,
  input  wire logic                rst_n,
  // Controller pins
  input  wire logic                sleep_request_n,
  input  wire logic                enable_high,
  input  wire logic                enable_hiz,
  output logic                     fault_flag_n_o,
  output logic                     fault_flag_n_oe,
  // Detectors
  input  wire logic                supply_undervoltage,
  input  wire logic                pump_undervoltage,
  input  wire logic [N_FET-1:0]    fet_current_limit,
  input  wire logic                thermal_shutdown,
  // Chopper side
  input  wire logic [N_BRIDGE-1:0] phase_drive_req,
  input  wire logic [N_BRIDGE-1:0] trip_comp_raw,
  output logic [N_BRIDGE-1:0]      bridge_drive,
  output logic [N_BRIDGE-1:0]      trip_comp,
  output logic                     bridge_hiz,
  output logic                     pump_en,
  output logic                     indexer_en,
  output logic                     logic_en,
  // Avalon-MM slave
  input  wire logic [3:0]          avs_address,
  input  wire logic                avs_read,
  input  wire logic                avs_write,
  input  wire logic [31:0]         avs_writedata,
  output logic [31:0]              avs_readdata,
  output logic                     avs_waitrequest
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  initial begin
    if (N_BRIDGE < 1 || N_FET < 1) begin
      $error("N_BRIDGE and N_FET must be at least 1");
    end
    if (OCP_FILT_CYCLES < 1 || OCP_FILT_CYCLES > 65535) begin
      $error("OCP_FILT_CYCLES out of range");
    end
    if (RETRY_CYCLES < 1 || RETRY_CYCLES > 65535) begin
      $error("RETRY_CYCLES out of range");
    end
    if (SLP_MIN_CYCLES < 1 || SLP_MAX_CYCLES <= SLP_MIN_CYCLES || SLP_MAX_CYCLES > 65534) begin
      $error("Sleep pulse bounds out of range");
    end
  end

  // ------------------------------------------------------------
  // Detector synchronisers
  // ------------------------------------------------------------
  localparam int unsigned NDET = N_FET + 3;

  logic [NDET-1:0] det_meta_reg;
  logic [NDET-1:0] det_reg;

  // Two stages; only the second stage is looked at
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      det_meta_reg <= '0;
      det_reg      <= '0;
    end else begin
      det_meta_reg <= {fet_current_limit, thermal_shutdown, pump_undervoltage,
                       supply_undervoltage};                 // [RQ16]
      det_reg      <= det_meta_reg;
    end
  end

  wire logic uv_live    = det_reg[0];
  wire logic puv_live   = det_reg[1];
  wire logic ot_live    = det_reg[2];
  wire logic ilim_any   = |det_reg[NDET-1:3];
  // Latched when enable floats, retry when it is driven high
  wire logic mode_latch = enable_hiz;                       // [RQ7] [RQ11]

  // ------------------------------------------------------------
  // Sleep pulse measurement
  // ------------------------------------------------------------
  logic [15:0] slp_cnt_reg;
  logic        slp_prev_reg;
  logic        clr_req;

  wire logic slp_rise  = sleep_request_n && !slp_prev_reg;
  // Strictly longer than the lower bound clears held faults
  wire logic slp_clear = slp_rise && (slp_cnt_reg > SLP_MIN_CYCLES[15:0]);   // [RQ14]
  // Only a low lasting the upper bound puts the block to sleep
  wire logic sleeping  = !sleep_request_n && (slp_cnt_reg >= SLP_MAX_CYCLES[15:0]); // [RQ14]
  wire logic fault_clr = slp_clear || clr_req;              // [RQ8] [RQ12]

  // Saturating low-time counter; cleared once the line has been high for two cycles
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      slp_cnt_reg  <= 16'h0000;
      slp_prev_reg <= 1'b1;
    end else begin
      slp_prev_reg <= sleep_request_n;
      if (sleep_request_n && slp_prev_reg) begin
        slp_cnt_reg <= 16'h0000;
      end else if (!sleep_request_n && slp_cnt_reg < SLP_MAX_CYCLES[15:0]) begin
        slp_cnt_reg <= slp_cnt_reg + 16'h0001;
      end
    end
  end

  // ------------------------------------------------------------
  // Overcurrent supervisor
  // ------------------------------------------------------------
  bfsup_oc_state_e oc_state_reg;
  bfsup_oc_state_e oc_state_next;
  logic [15:0]     ocp_cnt_reg;
  logic [15:0]     retry_cnt_reg;

  wire logic ocp_fire   = ilim_any && (ocp_cnt_reg >= OCP_FILT_CYCLES[15:0] - 16'h0001); // [RQ6]
  wire logic retry_done = (retry_cnt_reg >= RETRY_CYCLES[15:0]);
  // Limit must be gone; retry releases after the wait, either mode on a clear
  wire logic oc_release = !ilim_any &&
                          ((!mode_latch && retry_done) || fault_clr); // [RQ8] [RQ9]
  wire logic ocp_fault  = (oc_state_reg == BFSUP_OC_TRIP);

  always_comb begin
    oc_state_next = oc_state_reg;
    case (oc_state_reg)
      BFSUP_OC_RUN: begin
        if (ocp_fire) begin
          oc_state_next = BFSUP_OC_TRIP;                    // [RQ6]
        end
      end
      BFSUP_OC_TRIP: begin
        if (oc_release) begin
          oc_state_next = BFSUP_OC_RUN;
        end
      end
      default: begin
        oc_state_next = BFSUP_OC_TRIP;
      end
    endcase
  end

  // Filter counts a held limit; retry wait counts from the trip
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      oc_state_reg  <= BFSUP_OC_RUN;
      ocp_cnt_reg   <= 16'h0000;
      retry_cnt_reg <= 16'h0000;
    end else begin
      oc_state_reg <= oc_state_next;
      if (!ilim_any || ocp_fault) begin
        ocp_cnt_reg <= 16'h0000;
      end else if (!ocp_fire) begin
        ocp_cnt_reg <= ocp_cnt_reg + 16'h0001;
      end
      if (!ocp_fault) begin
        retry_cnt_reg <= 16'h0000;
      end else if (!retry_done) begin
        retry_cnt_reg <= retry_cnt_reg + 16'h0001;          // [RQ9]
      end
    end
  end

  // ------------------------------------------------------------
  // Thermal supervisor
  // ------------------------------------------------------------
  logic ot_hold_reg;

  // Detector drops only below threshold minus hysteresis;
  // a live detector wins over any clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ot_hold_reg <= 1'b0;
    end else if (ot_live) begin
      ot_hold_reg <= 1'b1;                                  // [RQ10]
    end else if (!mode_latch || fault_clr) begin
      ot_hold_reg <= 1'b0;                                  // [RQ12] [RQ13]
    end
  end

  wire logic ot_fault = ot_live || ot_hold_reg;

  // ------------------------------------------------------------
  // Gating and fault line
  // ------------------------------------------------------------
  logic ctrl_off_reg;

  wire logic any_fault  = uv_live || puv_live || ocp_fault || ot_fault;  // [RQ16]
  wire logic en_low     = !enable_high && !enable_hiz;
  wire logic bridge_off = uv_live || puv_live || ocp_fault || ot_fault ||
                          sleeping || en_low || ctrl_off_reg;  // [RQ4] [RQ5] [RQ6] [RQ15]
  // Pump survives pump undervoltage, overcurrent, enable low and the control off bit
  wire logic pump_off   = uv_live || ot_fault || sleeping;   // [RQ4] [RQ10]
  wire logic core_off   = uv_live || sleeping;              // [RQ10]

  // Registered so no output glitches from the decode
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      bridge_hiz      <= 1'b1;
      pump_en         <= 1'b0;
      indexer_en      <= 1'b0;
      logic_en        <= 1'b0;
      fault_flag_n_o  <= 1'b0;
      fault_flag_n_oe <= 1'b0;
    end else begin
      bridge_hiz      <= bridge_off;                        // [RQ15]
      pump_en         <= !pump_off;                         // [RQ5] [RQ6]
      indexer_en      <= !core_off;
      logic_en        <= !core_off;
      fault_flag_n_o  <= 1'b0;                              // Open drain only pulls low
      fault_flag_n_oe <= any_fault;                         // [RQ3]
    end
  end

  // ------------------------------------------------------------
  // Per-bridge blanking
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < N_BRIDGE; gi++) begin : g_bridge
      bfsup_blank #(
        .BLANK_CYCLES (BLANK_CYC)
      ) u_blank (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .drive_req (phase_drive_req[gi]),
        .kill      (bridge_off),
        .trip_raw  (trip_comp_raw[gi]),
        .drive     (bridge_drive[gi]),
        .trip      (trip_comp[gi])
      );
    end
  endgenerate

  // ------------------------------------------------------------
  // Avalon-MM slave
  // ------------------------------------------------------------
  // One wait cycle: first edge registers the answer, second completes
  wire logic        bus_req   = avs_read || avs_write;
  wire logic        bus_done  = bus_req && !avs_waitrequest;
  wire logic        hit_ctrl  = (avs_address == CTRL_OFS);
  wire logic        hit_stat  = (avs_address == STATUS_OFS);
  wire logic        wr_ctrl   = bus_done && avs_write && hit_ctrl;
  wire logic [31:0] ctrl_word = {30'h0, 1'b0, ctrl_off_reg};
  wire logic [31:0] stat_word = {24'h0, bridge_off, any_fault, mode_latch,
                                 sleeping, ot_fault, ocp_fault, puv_live, uv_live};
  wire logic [31:0] rd_mux    = hit_ctrl ? ctrl_word :
                                hit_stat ? stat_word : 32'h0;

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
    end else begin
      avs_waitrequest <= !(bus_req && avs_waitrequest);
      if (bus_req && avs_waitrequest) begin
        avs_readdata <= avs_read ? rd_mux : 32'h0;
      end
    end
  end

  // Control writes; the clear bit is a one-cycle strobe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_off_reg <= CTRL_BRIDGE_OFF_RST;
      clr_req      <= 1'b0;
    end else begin
      clr_req <= wr_ctrl && avs_writedata[CTRL_CLEAR_BIT];
      if (wr_ctrl) begin
        ctrl_off_reg <= avs_writedata[CTRL_BRIDGE_OFF_BIT];
      end
    end
  end

endmodule // bfsup_top

/* verification/bfsup_top_assertions.sv */
`timescale 1ns/1ps
module bfsup_top_assertions
  import bfsup_pkg::*;
#(
  parameter int unsigned N_BRIDGE        = 2,
  parameter int unsigned N_FET           = 8,
  parameter int unsigned OCP_FILT_CYCLES = OCP_FILT_CYC_DEF,
  parameter int unsigned RETRY_CYCLES    = RETRY_CYC_DEF
) (
  input wire logic                mclk,
  input wire logic                rst_n,
  input wire logic                sleep_request_n,
  input wire logic                enable_high,
  input wire logic                enable_hiz,
  input wire logic                fault_flag_n_oe,
  input wire logic                supply_undervoltage,
  input wire logic                pump_undervoltage,
  input wire logic [N_FET-1:0]    fet_current_limit,
  input wire logic                thermal_shutdown,
  input wire logic [N_BRIDGE-1:0] bridge_drive,
  input wire logic [N_BRIDGE-1:0] trip_comp,
  input wire logic                bridge_hiz,
  input wire logic                pump_en,
  input wire logic                indexer_en,
  input wire logic                avs_write
);
  logic [15:0] quiet_reg;
  logic [15:0] oc_reg;
  logic [15:0] on_reg;
  // Quiet means no detector up; counters saturate so long runs never wrap
  wire any_det = supply_undervoltage | pump_undervoltage | thermal_shutdown | (|fet_current_limit);
  wire hold_ok = enable_hiz & ~enable_high & sleep_request_n & ~avs_write & (quiet_reg > 16'h0008);
  // Cycle counters for the long-span checks
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      quiet_reg <= 16'h0000;
      oc_reg    <= 16'h0000;
      on_reg    <= 16'h0000;
    end else begin
      quiet_reg <= any_det ? 16'h0000 : quiet_reg + {15'h0000, ~&quiet_reg};
      oc_reg    <= (|fet_current_limit) ? oc_reg + {15'h0000, ~&oc_reg} : 16'h0000;
      on_reg    <= bridge_drive[0] ? on_reg + {15'h0000, ~&on_reg} : 16'h0000;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence s_supply_low;
    supply_undervoltage[*3];
  endsequence
  sequence s_disabled;
    (sleep_request_n && !enable_high && !enable_hiz)[*3];
  endsequence
  a_blank_start_hold: assert property (
    $rose(bridge_drive[0]) |-> (bridge_drive[0] && !trip_comp[0])[*8])
    else $error("drive ended or trip passed inside blanking");
  a_blank_trip_late: assert property (
    $rose(trip_comp[0]) |-> on_reg >= BLANK_CYC)
    else $error("trip passed before blanking ended");
  a_supply_uv_off: assert property (
    s_supply_low |-> ##[1:2] (fault_flag_n_oe && bridge_hiz && !pump_en && !indexer_en))
    else $error("supply low did not shut bridges and pump");
  a_pump_uv_off: assert property (
    pump_undervoltage[*3] |-> ##[1:2] (fault_flag_n_oe && bridge_hiz))
    else $error("pump low did not shut bridges");
  a_thermal_off: assert property (
    thermal_shutdown[*3] |-> ##[1:2] (fault_flag_n_oe && bridge_hiz && !pump_en))
    else $error("overheat did not shut bridges and pump");
  a_oc_filter_trip: assert property (
    oc_reg >= OCP_FILT_CYCLES + 5 |-> fault_flag_n_oe && bridge_hiz)
    else $error("held current limit did not trip");
  a_fault_has_cause: assert property (
    $rose(fault_flag_n_oe) |-> quiet_reg <= 16'h0003)
    else $error("fault raised without a detector");
  a_retry_releases: assert property (
    quiet_reg >= RETRY_CYCLES + 8 && enable_high && $past(enable_high) && $past(enable_high, 2)
    |-> !fault_flag_n_oe)
    else $error("retry mode kept the fault");
  a_latched_holds: assert property (
    hold_ok && $past(hold_ok) && $past(hold_ok, 2) && $past(hold_ok, 3) && $past(hold_ok, 4)
    && $past(fault_flag_n_oe) |-> fault_flag_n_oe)
    else $error("latched fault dropped without a clear");
  a_disabled_hiz: assert property (
    s_disabled |-> ##[0:2] bridge_hiz)
    else $error("enable low left bridges driven");
endmodule // bfsup_top_assertions

bind bfsup_top bfsup_top_assertions #(
  .N_BRIDGE(N_BRIDGE), .N_FET(N_FET), .OCP_FILT_CYCLES(OCP_FILT_CYCLES),
  .RETRY_CYCLES(RETRY_CYCLES)
) u_chk (
  .mclk(mclk), .rst_n(rst_n), .sleep_request_n(sleep_request_n), .enable_high(enable_high),
  .enable_hiz(enable_hiz), .fault_flag_n_oe(fault_flag_n_oe),
  .supply_undervoltage(supply_undervoltage), .pump_undervoltage(pump_undervoltage),
  .fet_current_limit(fet_current_limit), .thermal_shutdown(thermal_shutdown),
  .bridge_drive(bridge_drive), .trip_comp(trip_comp), .bridge_hiz(bridge_hiz),
  .pump_en(pump_en), .indexer_en(indexer_en), .avs_write(avs_write)
);

/* verification/bfsup_ctrl_model.sv */
`timescale 1ns/1ps
module bfsup_ctrl_model (
  input  wire logic mclk,
  input  wire logic fault_flag_n_o,
  input  wire logic fault_flag_n_oe,
  output logic      sleep_request_n,
  output logic      enable_high,
  output logic      enable_hiz,
  output logic      fault_line
);
  // Pull-up holds the line high unless the device sinks it
  assign fault_line = fault_flag_n_oe ? fault_flag_n_o : 1'b1;
  // Awake and in retry mode from power-up
  initial begin
    sleep_request_n = 1'b1;
    enable_high     = 1'b1;
    enable_hiz      = 1'b0;
  end
  // Mode 0 retry, 1 latched (floating pin), 2 enable low; may change any time
  task automatic set_mode(input int m);
    @(posedge mclk);
    enable_high <= (m == 0);
    enable_hiz  <= (m == 1);
  endtask
  // Caller keeps n inside the clear window, or the device may go to sleep
  task automatic sleep_pulse(input int n);
    @(posedge mclk);
    sleep_request_n <= 1'b0;
    repeat (n) @(posedge mclk);
    sleep_request_n <= 1'b1;
  endtask
endmodule // bfsup_ctrl_model

/* verification/test_bridge_fault_supervisor.sv */
`timescale 1ns/1ps
module test_bridge_fault_supervisor;
  import bfsup_pkg::*;
  // Short counts keep the run brief; expectations derive from these
  localparam int OCF = 4;
  localparam int RET = 8;
  logic        mclk, rst_n, sleep_request_n, enable_high, enable_hiz;
  logic        fault_flag_n_o, fault_flag_n_oe, fault_line;
  logic        supply_undervoltage, pump_undervoltage, thermal_shutdown;
  logic [7:0]  fet_current_limit;
  logic [1:0]  phase_drive_req, trip_comp_raw, bridge_drive, trip_comp;
  logic        bridge_hiz, pump_en, indexer_en, logic_en;
  logic [3:0]  avs_address;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [31:0] avs_writedata, avs_readdata;
  int          error_cnt, checks_done;

  bfsup_top #(.OCP_FILT_CYCLES(OCF), .RETRY_CYCLES(RET), .SLP_MIN_CYCLES(20),
    .SLP_MAX_CYCLES(40)) u_dut (
    .mclk(mclk), .rst_n(rst_n), .sleep_request_n(sleep_request_n), .enable_high(enable_high),
    .enable_hiz(enable_hiz), .fault_flag_n_o(fault_flag_n_o), .fault_flag_n_oe(fault_flag_n_oe),
    .supply_undervoltage(supply_undervoltage), .pump_undervoltage(pump_undervoltage),
    .fet_current_limit(fet_current_limit), .thermal_shutdown(thermal_shutdown),
    .phase_drive_req(phase_drive_req), .trip_comp_raw(trip_comp_raw),
    .bridge_drive(bridge_drive), .trip_comp(trip_comp), .bridge_hiz(bridge_hiz),
    .pump_en(pump_en), .indexer_en(indexer_en), .logic_en(logic_en),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  bfsup_ctrl_model u_ctrl (.mclk(mclk), .fault_flag_n_o(fault_flag_n_o),
    .fault_flag_n_oe(fault_flag_n_oe), .sleep_request_n(sleep_request_n),
    .enable_high(enable_high), .enable_hiz(enable_hiz), .fault_line(fault_line));

  // 250 MHz clock
  always #2 mclk = ~mclk;

  // ----------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Request held until waitrequest is sampled low; only the watchdog ends a hang
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge mclk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge mclk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------
  // Bridge 1 request is short, bridge 0 held with its comparator tripped
  task automatic t_blank;
    phase_drive_req <= 2'b11;
    trip_comp_raw   <= 2'b01;
    cyc(2);
    phase_drive_req <= 2'b01;
    cyc(200);
    chk("drive in blank", bridge_drive, 2'b11);
    chk("trip in blank", trip_comp, 2'b00);
    cyc(60);
    chk("drive after blank", bridge_drive, 2'b01);
    chk("trip after blank", trip_comp, 2'b01);
    phase_drive_req <= 2'b00;
    trip_comp_raw   <= 2'b00;
    cyc(260);
  endtask
  task automatic t_undervolt;
    supply_undervoltage <= 1'b1;
    cyc(4);
    chk("supply uv", {fault_line, bridge_hiz, pump_en, indexer_en, logic_en}, 5'h08);
    supply_undervoltage <= 1'b0;
    cyc(5);
    chk("supply ok", {fault_line, bridge_hiz, pump_en, indexer_en, logic_en}, 5'h17);
    pump_undervoltage <= 1'b1;
    cyc(4);
    chk("pump uv", {fault_line, bridge_hiz, pump_en}, 3'h3);
    pump_undervoltage <= 1'b0;
    cyc(5);
    chk("pump ok", {fault_line, bridge_hiz, pump_en}, 3'h5);
  endtask
  task automatic t_ocp;
    logic [31:0] q;
    for (int m = 0; m < 2; m++) begin
      u_ctrl.set_mode(m);
      fet_current_limit <= (m == 0) ? 8'h01 : 8'h80;
      cyc(OCF + 6);
      chk("oc trip", {fault_flag_n_oe, bridge_hiz, pump_en}, 3'h7);
      fet_current_limit <= 8'h00;
      cyc(RET + 8);
      chk("oc after", fault_flag_n_oe, m);
      if (m == 1) begin
        bus(1'b0, 4'h4, 32'h0, q);
        chk("status latched", q[5], 1'b1);
        u_ctrl.sleep_pulse(30);
        cyc(4);
        chk("pulse clears", {fault_flag_n_oe, pump_en}, 2'b01);
      end
    end
  endtask
  task automatic t_thermal;
    logic [31:0] q;
    for (int m = 0; m < 2; m++) begin
      u_ctrl.set_mode(m);
      thermal_shutdown <= 1'b1;
      cyc(4);
      chk("thermal_shutdown", {fault_flag_n_oe, bridge_hiz, pump_en, indexer_en}, 4'hD);
      thermal_shutdown <= 1'b0;
      cyc(5);
      chk("thermal_shutdown after", fault_flag_n_oe, m);
      if (m == 1) begin
        bus(1'b1, 4'h0, 32'h2, q);
        cyc(4);
        chk("ctrl clears", fault_flag_n_oe, 1'b0);
      end
    end
  endtask
  // Control reset value, read-back, status, unmapped place
  task automatic t_bus;
    logic [31:0] q;
    bus(1'b0, 4'h0, 32'h0, q);
    chk("ctrl reset", q, 32'h0);
    bus(1'b1, 4'h0, 32'h1, q);
    bus(1'b1, 4'h8, 32'hFFFFFFFF, q);
    bus(1'b0, 4'h0, 32'h0, q);
    chk("ctrl rw", q, 32'h1);
    bus(1'b0, 4'h8, 32'h0, q);
    chk("unmapped", q, 32'h0);
    bus(1'b0, 4'h4, 32'h0, q);
    chk("status off", {q[7], bridge_hiz}, 2'b11);
    bus(1'b1, 4'h0, 32'h0, q);
    cyc(3);
    chk("bridge on", bridge_hiz, 1'b0);
  endtask
  task automatic t_disable;
    u_ctrl.set_mode(2);
    phase_drive_req <= 2'b11;
    cyc(5);
    chk("disabled", {bridge_hiz, bridge_drive}, 3'h4);
    phase_drive_req <= 2'b00;
    u_ctrl.set_mode(0);
    cyc(5);
    chk("enabled", bridge_hiz, 1'b0);
  endtask

  // Watchdog sized well beyond the roughly 700 cycles the run needs
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    print_verdict();
  end
  // Main sequence
  initial begin
    mclk = 1'b0;
    rst_n = 1'b0;
    {supply_undervoltage, pump_undervoltage, thermal_shutdown} = 3'h0;
    fet_current_limit = 8'h00;
    phase_drive_req = 2'b00;
    trip_comp_raw = 2'b00;
    {avs_read, avs_write, avs_address, avs_writedata} = 38'h0;
    error_cnt = 0;
    checks_done = 0;
    cyc(8);
    rst_n <= 1'b1;
    cyc(6);
    chk("fault idle", fault_line, 1'b1);
    t_blank();
    t_undervolt();
    t_ocp();
    t_thermal();
    t_bus();
    t_disable();
    print_verdict();
  end
endmodule // test_bridge_fault_supervisor
